// ---- bench/jtag_tester.sv ----
`timescale 1ns/10ps
module jtag_tester (
  output logic tck,     // Test clock, still between frames
  output logic tms,     // Mode select
  output logic tdi,     // Serial data to device
  output logic trst_n,  // Test reset, active low
  input wire logic tdo  // Serial data from device
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // Long low phase so the resynchronised data out has settled before sampling
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #96;
    q = tdo;
    tck = 1'b1;
    #64;
    tck = 1'b0;
  endtask : step

  task automatic tlr;
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : tlr

  // From idle: one frame through the instruction or data path, back to idle
  task automatic scan(input logic ir, input logic [tap_pkg::SCAN_LEN-1:0] d, input int n,
                      output logic [tap_pkg::SCAN_LEN-1:0] q);
    logic b;
    q = '0;
    step(1'b1, 1'b0, b);
    if (ir)
      step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, ~tdi, b);
  endtask : scan

  task automatic pulse_trst;
    logic b;
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
    #100;
    step(1'b0, 1'b0, b);
  endtask : pulse_trst
endmodule : jtag_tester

// ---- bench/tap_instruction_and_scan_regs_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tap_instruction_and_scan_regs_tb;
  localparam int SL = tap_pkg::SCAN_LEN;
  localparam logic [31:0] PRE_OUT = 32'h6B2D_91E4;
  localparam logic [31:0] PRE_CTL = 32'h00FF_F00F;
  localparam logic [31:0] IR_ADDR = tap_pkg::TEST_INSTRUCTION_ADDR;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, extest_active, debug_reset, debug_irq;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [15:0] cpu_rdata;
  logic [31:0] d_pad_in = 32'hA5C3_5A3C;
  logic [31:0] core_d_out = 32'h1234_8765;
  logic [31:0] core_d_oe_n = 32'hF0F0_0F0F;
  logic [31:0] d_pad_out, d_pad_oe_n;
  logic [SL-1:0] other_cell_in = SL'({11{32'h3C96_A55A}});
  logic [SL-1:0] other_cell_out;
  int fail_count = 0;
  int n_tests = 0;
  int irq_n = 0;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (debug_irq === 1'b1) irq_n++;

  jtag_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  tap_instruction_and_scan_regs dut (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_rdata(cpu_rdata), .d_pad_in(d_pad_in), .core_d_out(core_d_out),
    .core_d_oe_n(core_d_oe_n), .d_pad_out(d_pad_out), .d_pad_oe_n(d_pad_oe_n),
    .other_cell_in(other_cell_in), .other_cell_out(other_cell_out),
    .extest_active(extest_active), .debug_reset(debug_reset), .debug_irq(debug_irq));

  task automatic cpu_read(input logic [31:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #2;
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(posedge sys_clk);
    #2;
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask : cpu_read

  // Low twelve bits shifted as zeros so the forced ones are visible
  task automatic load_ir(input logic [3:0] c, output logic [15:0] q);
    logic [SL-1:0] w;
    tester.scan(1'b1, SL'({c, 12'h000}), 16, w);
    q = w[15:0];
    repeat (6) @(posedge sys_clk);
    #2;
  endtask : load_ir

  task automatic t_reset_vals;
    logic [15:0] d;
    cpu_read(IR_ADDR, d);
    `CHK("ir_reset", tap_pkg::IR_RESET, d)
    cpu_read(32'hA400_0204, d);
    `CHK("unmapped_read", 16'h0000, d)
    `CHK("tdo_oe_n_idle", 1'b1, tdo_oe_n)
    `CHK("debug_reset_idle", 1'b0, debug_reset)
  endtask : t_reset_vals

  task automatic t_cpu_write;
    logic [15:0] d;
    @(posedge sys_clk);
    #2;
    cpu_wr = 1'b1;
    cpu_addr = IR_ADDR;
    @(posedge sys_clk);
    #2;
    cpu_wr = 1'b0;
    cpu_read(IR_ADDR, d);
    `CHK("ir_after_write", tap_pkg::IR_RESET, d)
  endtask : t_cpu_write

  task automatic t_bypass;
    logic [SL-1:0] got;
    tester.scan(1'b0, SL'(8'hB4), 8, got);
    `CHK("bypass_capture", 1'b0, got[0])
    `CHK("bypass_delay", 7'h34, got[7:1])
  endtask : t_bypass

  task automatic t_sample_preload;
    logic [15:0] q;
    logic [15:0] d;
    logic [SL-1:0] pre;
    logic [SL-1:0] got;
    load_ir(tap_pkg::CMD_SAMPLE, q);
    `CHK("ir_capture", tap_pkg::IR_RESET, q)
    cpu_read(IR_ADDR, d);
    `CHK("ir_sample", {tap_pkg::CMD_SAMPLE, tap_pkg::RSVD_ONES}, d)
    pre = '0;
    pre[306:275] = PRE_OUT;
    pre[274:243] = PRE_CTL;
    tester.scan(1'b0, pre, SL, got);
    `CHK("cap_din", d_pad_in, got[346:315])
    `CHK("cap_dout", core_d_out, got[306:275])
    `CHK("cap_dctl", core_d_oe_n, got[274:243])
    `CHK("cap_other", other_cell_in[242:0], got[242:0])
    `CHK("sample_pads", core_d_out, d_pad_out)
    `CHK("sample_oe", core_d_oe_n, d_pad_oe_n)
    `CHK("preload_out", PRE_OUT, other_cell_out[306:275])
  endtask : t_sample_preload

  task automatic t_extest;
    logic [15:0] q;
    logic [15:0] d;
    load_ir(tap_pkg::CMD_EXTEST, q);
    `CHK("ir_capture2", {tap_pkg::CMD_SAMPLE, tap_pkg::RSVD_ONES}, q)
    `CHK("extest_on", 1'b1, extest_active)
    `CHK("extest_pads", PRE_OUT, d_pad_out)
    `CHK("extest_oe", PRE_CTL, d_pad_oe_n)
    tester.tlr();
    repeat (6) @(posedge sys_clk);
    #2;
    `CHK("tlr_extest_off", 1'b0, extest_active)
    `CHK("tlr_pads", core_d_out, d_pad_out)
    cpu_read(IR_ADDR, d);
    `CHK("tlr_ir", tap_pkg::IR_RESET, d)
  endtask : t_extest

  task automatic t_debug_cmds;
    logic [15:0] q;
    logic [15:0] d;
    logic [SL-1:0] got;
    int n0;
    load_ir(tap_pkg::CMD_DRST_ASSERT, q);
    `CHK("dbg_rst_set", 1'b1, debug_reset)
    for (int c = 10; c <= 11; c++) begin
      n0 = irq_n;
      load_ir(4'(c), q);
      `CHK("irq_pulses", n0 + 1, irq_n)
    end
    tester.pulse_trst();
    cpu_read(IR_ADDR, d);
    `CHK("trst_ir", tap_pkg::IR_RESET, d)
    tester.scan(1'b0, SL'(2'b11), 2, got);
    `CHK("trst_bypass", 1'b0, got[0])
    n0 = irq_n;
    load_ir(tap_pkg::CMD_DRST_NEGATE, q);
    `CHK("dbg_rst_clr", 1'b0, debug_reset)
    `CHK("no_irq", n0, irq_n)
  endtask : t_debug_cmds

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // The whole sequence needs well under 300 us of link traffic
  initial begin
    #1_000_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    #2;
    tester.tlr();
    t_reset_vals();
    t_cpu_write();
    t_bypass();
    t_sample_preload();
    t_extest();
    t_debug_cmds();
    print_verdict();
  end
endmodule : tap_instruction_and_scan_regs_tb

// ---- rtl/pin_sampler.sv ----
`timescale 1ns/10ps
module pin_sampler #(
  parameter int DATA_W = 32
) (
  input wire logic sys_clk,            // System clock
  input wire logic rst,                // Async reset
  input wire logic tck,                // Test clock pin
  input wire logic tms,                // Mode select pin
  input wire logic tdi,                // Serial data in pin
  input wire logic trst_n,             // Test reset pin
  input wire logic [DATA_W-1:0] d_in,  // Data bus pad inputs
  scan_link_if.sampler lnk             // Synchronised view
);
  localparam int W = DATA_W + 4;
  logic [W-1:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic tck_d_r, tck_d_nxt;

  // Stage one feeds stage two only; edges are found on stage two
  always_comb begin
    s1_nxt = {d_in, trst_n, tdi, tms, tck};
    s2_nxt = s1_r;
    tck_d_nxt = s2_r[0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      tck_d_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      tck_d_r <= tck_d_nxt;
    end
  end

  assign lnk.tck_rise = s2_r[0] & ~tck_d_r;
  assign lnk.tck_fall = ~s2_r[0] & tck_d_r;
  assign lnk.tms = s2_r[1];
  assign lnk.tdi = s2_r[2];
  assign lnk.trst_n = s2_r[3];
  assign lnk.d_in = s2_r[W-1:4];
endmodule : pin_sampler

// ---- rtl/scan_link_if.sv ----
`timescale 1ns/10ps
interface scan_link_if #(parameter int DATA_W = 32);
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_n;
  logic [DATA_W-1:0] d_in;
  modport sampler (output tck_rise, output tck_fall, output tms, output tdi,
    output trst_n, output d_in);
  modport core (input tck_rise, input tck_fall, input tms, input tdi,
    input trst_n, input d_in);
endinterface : scan_link_if

// ---- rtl/tap_instruction_and_scan_regs.sv ----
`timescale 1ns/10ps
module tap_instruction_and_scan_regs #(
  parameter int DATA_W = 32,
  parameter int SCAN_LEN = tap_pkg::SCAN_LEN
) (
  input wire logic sys_clk,                   // 50 MHz system clock
  input wire logic rst,                       // Async reset, active high
  input wire logic tck,                       // Test clock pin
  input wire logic tms,                       // Mode select pin
  input wire logic tdi,                       // Serial data in pin
  input wire logic trst_n,                    // Test reset pin, active low
  output logic tdo,                           // Serial data out
  output logic tdo_oe_n,                      // Low while shifting out
  input wire logic cpu_rd,                    // Processor read strobe
  input wire logic cpu_wr,                    // Processor write strobe, ignored
  input wire logic [31:0] cpu_addr,           // Processor address
  output logic [15:0] cpu_rdata,              // Processor read data
  input wire logic [DATA_W-1:0] d_pad_in,     // Data bus pad inputs
  input wire logic [DATA_W-1:0] core_d_out,   // Functional data out
  input wire logic [DATA_W-1:0] core_d_oe_n,  // Functional drive enable, low drives
  output logic [DATA_W-1:0] d_pad_out,        // Data bus pad outputs
  output logic [DATA_W-1:0] d_pad_oe_n,       // Low while pad is driven
  input wire logic [SCAN_LEN-1:0] other_cell_in,   // Capture for address/control cells
  output logic [SCAN_LEN-1:0] other_cell_out,      // Update latches of all cells
  output logic extest_active,                 // Pads under scan control
  output logic debug_reset,                   // Debug reset request level
  output logic debug_irq                      // Debug interrupt, one-cycle pulse
);
  scan_link_if #(.DATA_W(DATA_W)) lnk ();

  pin_sampler #(.DATA_W(DATA_W)) u_sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .trst_n(trst_n),
    .d_in(d_pad_in),
    .lnk(lnk.sampler)
  );

  function automatic tap_pkg::tap_state_t tap_next(tap_pkg::tap_state_t s, logic m);
    case (s)
      tap_pkg::TLR: tap_next = m ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: tap_next = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: tap_next = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: tap_next = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: tap_next = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: tap_next = m ? tap_pkg::UPD_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: tap_next = m ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: tap_next = m ? tap_pkg::UPD_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPD_DR: tap_next = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: tap_next = m ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: tap_next = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: tap_next = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: tap_next = m ? tap_pkg::UPD_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: tap_next = m ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: tap_next = m ? tap_pkg::UPD_IR : tap_pkg::SHIFT_IR;
      tap_pkg::UPD_IR: tap_next = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default: tap_next = tap_pkg::TLR;
    endcase
  endfunction : tap_next

  function automatic logic is_data_cell(int i);
    is_data_cell = (i <= tap_pkg::DIN_HI && i >= tap_pkg::DIN_LO) ||
                   (i <= tap_pkg::DOUT_HI && i >= tap_pkg::DCTL_LO);
  endfunction : is_data_cell

  tap_pkg::tap_state_t state_r, state_nxt;
  logic [15:0] ir_shift_r, ir_shift_nxt;
  logic [15:0] test_instruction_r, test_instruction_nxt;
  logic single_bit_bypass_reg_r, single_bit_bypass_reg_nxt;
  logic [SCAN_LEN-1:0] pin_scan_chain_r, pin_scan_chain_nxt;
  logic [SCAN_LEN-1:0] upd_r, upd_nxt;
  logic tdo_r, tdo_nxt, tdo_oe_n_r, tdo_oe_n_nxt;
  logic debug_reset_r, debug_reset_nxt, debug_irq_r, debug_irq_nxt;
  logic [15:0] cpu_rdata_r, cpu_rdata_nxt;
  logic [3:0] test_command_field;
  logic scan_sel, tap_init, upd_ir_ev;

  assign test_command_field = test_instruction_r[tap_pkg::CMD_HI:tap_pkg::CMD_LO];
  assign scan_sel = (test_command_field == tap_pkg::CMD_EXTEST) ||
                    (test_command_field == tap_pkg::CMD_SAMPLE);
  // Sampled test reset still overrides every clock edge, so no test clock is needed
  assign tap_init = !lnk.trst_n || state_r == tap_pkg::TLR;
  assign upd_ir_ev = lnk.tck_fall && state_r == tap_pkg::UPD_IR;

  always_comb begin
    state_nxt = state_r;
    ir_shift_nxt = ir_shift_r;
    test_instruction_nxt = test_instruction_r;
    single_bit_bypass_reg_nxt = single_bit_bypass_reg_r;
    pin_scan_chain_nxt = pin_scan_chain_r;
    upd_nxt = upd_r;
    tdo_nxt = tdo_r;
    tdo_oe_n_nxt = tdo_oe_n_r;
    debug_reset_nxt = debug_reset_r;
    debug_irq_nxt = 1'b0;
    if (lnk.tck_rise) begin
      state_nxt = tap_next(state_r, lnk.tms);
      case (state_r)
        tap_pkg::CAP_IR: ir_shift_nxt = test_instruction_r;
        tap_pkg::SHIFT_IR: ir_shift_nxt = {lnk.tdi, ir_shift_r[15:1]};
        tap_pkg::CAP_DR: begin
          single_bit_bypass_reg_nxt = 1'b0;
          if (scan_sel) begin
            for (int i = 0; i < SCAN_LEN; i++) begin
              if (!is_data_cell(i)) pin_scan_chain_nxt[i] = other_cell_in[i];
            end
            pin_scan_chain_nxt[tap_pkg::DIN_HI:tap_pkg::DIN_LO] = lnk.d_in;
            pin_scan_chain_nxt[tap_pkg::DOUT_HI:tap_pkg::DOUT_LO] = d_pad_out;
            pin_scan_chain_nxt[tap_pkg::DCTL_HI:tap_pkg::DCTL_LO] = d_pad_oe_n;
          end
        end
        tap_pkg::SHIFT_DR: begin
          if (scan_sel) begin
            pin_scan_chain_nxt = {lnk.tdi, pin_scan_chain_r[SCAN_LEN-1:1]};
          end else begin
            single_bit_bypass_reg_nxt = lnk.tdi;
          end
        end
        default: ;
      endcase
    end
    if (lnk.tck_fall) begin
      // Output changes on the falling edge so the tester samples a settled bit
      tdo_oe_n_nxt = !(state_r == tap_pkg::SHIFT_IR || state_r == tap_pkg::SHIFT_DR);
      if (state_r == tap_pkg::SHIFT_IR) tdo_nxt = ir_shift_r[0];
      else if (state_r == tap_pkg::SHIFT_DR) begin
        tdo_nxt = scan_sel ? pin_scan_chain_r[0] : single_bit_bypass_reg_r;
      end
      if (state_r == tap_pkg::UPD_DR && scan_sel) upd_nxt = pin_scan_chain_r;
    end
    if (upd_ir_ev) begin
      test_instruction_nxt = {ir_shift_r[tap_pkg::CMD_HI:tap_pkg::CMD_LO],
                              tap_pkg::RSVD_ONES};
      case (ir_shift_r[tap_pkg::CMD_HI:tap_pkg::CMD_LO])
        tap_pkg::CMD_DRST_ASSERT: debug_reset_nxt = 1'b1;
        tap_pkg::CMD_DRST_NEGATE: debug_reset_nxt = 1'b0;
        default: begin
          if (ir_shift_r[tap_pkg::CMD_HI:tap_pkg::CMD_HI-2] == tap_pkg::CMD_DINT_TOP) begin
            debug_irq_nxt = 1'b1;
          end
        end
      endcase
    end
    if (tap_init) begin
      test_instruction_nxt = tap_pkg::IR_RESET;
      single_bit_bypass_reg_nxt = tap_pkg::BYPASS_RESET;
      pin_scan_chain_nxt = {SCAN_LEN{tap_pkg::SCAN_RESET}};
      upd_nxt = {SCAN_LEN{tap_pkg::SCAN_RESET}};
      tdo_oe_n_nxt = 1'b1;
      if (!lnk.trst_n) state_nxt = tap_pkg::TLR;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= tap_pkg::TLR;
      ir_shift_r <= tap_pkg::IR_RESET;
      test_instruction_r <= tap_pkg::IR_RESET;
      single_bit_bypass_reg_r <= tap_pkg::BYPASS_RESET;
      pin_scan_chain_r <= '0;
      upd_r <= '0;
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
      debug_reset_r <= 1'b0;
      debug_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ir_shift_r <= ir_shift_nxt;
      test_instruction_r <= test_instruction_nxt;
      single_bit_bypass_reg_r <= single_bit_bypass_reg_nxt;
      pin_scan_chain_r <= pin_scan_chain_nxt;
      upd_r <= upd_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_n_r <= tdo_oe_n_nxt;
      debug_reset_r <= debug_reset_nxt;
      debug_irq_r <= debug_irq_nxt;
    end
  end

  // Processor side: read only; cpu_wr is accepted and discarded
  always_comb begin
    cpu_rdata_nxt = cpu_rdata_r;
    if (cpu_rd) begin
      cpu_rdata_nxt = (cpu_addr == tap_pkg::TEST_INSTRUCTION_ADDR) ?
                      test_instruction_r : 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cpu_rdata_r <= 16'h0000;
    else cpu_rdata_r <= cpu_rdata_nxt;
  end

  assign extest_active = test_command_field == tap_pkg::CMD_EXTEST;
  always_comb begin
    d_pad_out = core_d_out;
    d_pad_oe_n = core_d_oe_n;
    if (extest_active) begin
      d_pad_out = upd_r[tap_pkg::DOUT_HI:tap_pkg::DOUT_LO];
      d_pad_oe_n = upd_r[tap_pkg::DCTL_HI:tap_pkg::DCTL_LO];
    end
  end

  assign other_cell_out = upd_r;
  assign tdo = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;
  assign cpu_rdata = cpu_rdata_r;
  assign debug_reset = debug_reset_r;
  assign debug_irq = debug_irq_r;

  property p_bypass_out;
    @(posedge sys_clk) disable iff (rst)
    (lnk.tck_fall && state_r == tap_pkg::SHIFT_DR && test_command_field == tap_pkg::CMD_BYPASS)
      |=> tdo_r == $past(single_bit_bypass_reg_r) && !tdo_oe_n_r;
  endproperty
  a_bypass_out: assert property (p_bypass_out) else $error("bypass bit not on tdo");
  property p_trst_init;
    @(posedge sys_clk) disable iff (rst)
    !lnk.trst_n |=> test_instruction_r == tap_pkg::IR_RESET && state_r == tap_pkg::TLR;
  endproperty
  a_trst_init: assert property (p_trst_init) else $error("test reset missed");
  property p_tlr_init;
    @(posedge sys_clk) disable iff (rst)
    state_r == tap_pkg::TLR |=> test_instruction_r == tap_pkg::IR_RESET && !upd_r[0];
  endproperty
  a_tlr_init: assert property (p_tlr_init) else $error("reset state did not init");
  property p_rsvd_ones;
    @(posedge sys_clk) disable iff (rst)
    test_instruction_r[11:0] == tap_pkg::RSVD_ONES;
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) else $error("reserved bits not one");
  property p_cpu_no_write;
    @(posedge sys_clk) disable iff (rst)
    (cpu_wr && !upd_ir_ev && !tap_init) |=> $stable(test_instruction_r);
  endproperty
  a_cpu_no_write: assert property (p_cpu_no_write) else $error("cpu write changed reg");
  property p_cpu_read;
    @(posedge sys_clk) disable iff (rst)
    (cpu_rd && cpu_addr == tap_pkg::TEST_INSTRUCTION_ADDR)
      |=> cpu_rdata == $past(test_instruction_r);
  endproperty
  a_cpu_read: assert property (p_cpu_read) else $error("wrong read data");
  property p_drst;
    @(posedge sys_clk) disable iff (rst)
    (upd_ir_ev && ir_shift_r[15:12] == tap_pkg::CMD_DRST_ASSERT) |=> debug_reset ##1 debug_reset;
  endproperty
  a_drst: assert property (p_drst) else $error("debug reset not asserted");
  property p_irq_pulse;
    @(posedge sys_clk) disable iff (rst)
    debug_irq |-> $past(upd_ir_ev) ##1 !debug_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("debug irq not a pulse");
  property p_pin_drive;
    @(posedge sys_clk) disable iff (rst)
    (extest_active && !upd_r[tap_pkg::DCTL_LO])
      |-> !d_pad_oe_n[0] && d_pad_out[0] == upd_r[tap_pkg::DOUT_LO];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("control cell ignored");
  property p_chain_entry;
    @(posedge sys_clk) disable iff (rst)
    (lnk.tck_rise && state_r == tap_pkg::SHIFT_DR && scan_sel && !tap_init)
      |=> pin_scan_chain_r[tap_pkg::DIN_HI] == $past(lnk.tdi);
  endproperty
  a_chain_entry: assert property (p_chain_entry) else $error("chain entry wrong");
  property p_drst_clr;
    @(posedge sys_clk) disable iff (rst)
    (upd_ir_ev && ir_shift_r[15:12] == tap_pkg::CMD_DRST_NEGATE) |=> !debug_reset;
  endproperty
  a_drst_clr: assert property (p_drst_clr) else $error("debug reset not negated");
  // The command field must come only from the serial shift stage
  property p_ir_update;
    @(posedge sys_clk) disable iff (rst)
    (upd_ir_ev && !tap_init)
      |=> test_instruction_r[15:12] == $past(ir_shift_r[tap_pkg::CMD_HI:tap_pkg::CMD_LO]);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("command not updated");
  property p_ir_out;
    @(posedge sys_clk) disable iff (rst)
    (lnk.tck_fall && state_r == tap_pkg::SHIFT_IR && lnk.trst_n)
      |=> !tdo_oe_n_r && tdo_r == $past(ir_shift_r[0]);
  endproperty
  a_ir_out: assert property (p_ir_out) else $error("instruction bit not on tdo");
  c_bypass: cover property (@(posedge sys_clk) disable iff (rst)
    state_r == tap_pkg::SHIFT_DR && test_command_field == tap_pkg::CMD_BYPASS);
  c_extest: cover property (@(posedge sys_clk) disable iff (rst) extest_active && !d_pad_oe_n[0]);
  c_drst: cover property (@(posedge sys_clk) disable iff (rst) $rose(debug_reset));
  c_irq: cover property (@(posedge sys_clk) disable iff (rst) debug_irq);
  c_scan_shift: cover property (@(posedge sys_clk) disable iff (rst)
    lnk.tck_rise && state_r == tap_pkg::SHIFT_DR && scan_sel);
endmodule : tap_instruction_and_scan_regs

// ---- rtl/tap_pkg.sv ----
package tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  localparam int IR_W = 16;
  localparam logic [15:0] IR_RESET = 16'hFFFF;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 12;
  localparam logic [11:0] RSVD_ONES = 12'hFFF;
  localparam logic [3:0] CMD_EXTEST = 4'h0;
  localparam logic [3:0] CMD_SAMPLE = 4'h4;
  localparam logic [3:0] CMD_DRST_NEGATE = 4'h6;
  localparam logic [3:0] CMD_DRST_ASSERT = 4'h7;
  localparam logic [2:0] CMD_DINT_TOP = 3'h5;
  localparam logic [3:0] CMD_BYPASS = 4'hF;
  localparam logic [31:0] TEST_INSTRUCTION_ADDR = 32'hA4000200;
  localparam int SCAN_LEN = 347;
  localparam int DIN_HI = 346;
  localparam int DIN_LO = 315;
  localparam int DOUT_HI = 306;
  localparam int DOUT_LO = 275;
  localparam int DCTL_HI = 274;
  localparam int DCTL_LO = 243;
  localparam logic SCAN_RESET = 1'b0;
  localparam logic BYPASS_RESET = 1'b0;
endpackage : tap_pkg
